/* include/brs_pkg.sv */
/*
 * Shared constants and types of the branch record stack: register
 * offsets, field positions, reset values and the transfer kinds.
 * Assumes a 64-bit register port with byte-free word addressing.
 */
package brs_pkg;

    // Stack geometry
    localparam int N_ENTRIES = 16;
    localparam int PTR_W     = 4;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 64;

    // Register offsets (one 64-bit register per address)
    localparam logic [ADDR_W-1:0] OFS_PTR      = 8'h01;
    localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h02;
    localparam logic [ADDR_W-1:0] OFS_CAP      = 8'h03;
    localparam logic [ADDR_W-1:0] OFS_LER_SRC  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_LER_DST  = 8'h05;
    localparam logic [ADDR_W-1:0] OFS_CFG      = 8'h06;
    localparam logic [ADDR_W-1:0] OFS_IDENT    = 8'h07;
    localparam logic [ADDR_W-1:0] OFS_SRC_BASE = 8'h40;
    localparam logic [ADDR_W-1:0] OFS_DST_BASE = 8'h60;

    // Field positions
    localparam int CTRL_EN_BIT      = 0;
    localparam int CTRL_TRACE_BIT   = 6;
    localparam int CTRL_FREEZE_BIT  = 11;
    localparam int CFG_PACK_BIT     = 8;
    localparam int FMT_W            = 6;
    localparam int IDENT_PRESENT_BIT = 15;
    localparam int FLAG_MISPRED_BIT = 63;

    // Stored address formats
    localparam logic [FMT_W-1:0] FMT_CS32        = 6'h00;
    localparam logic [FMT_W-1:0] FMT_LIP64       = 6'h01;
    localparam logic [FMT_W-1:0] FMT_EIP64       = 6'h02;
    localparam logic [FMT_W-1:0] FMT_EIP64_FLAGS = 6'h03;

    // Reset values
    localparam logic [DATA_W-1:0] CTRL_RST = 64'h0;
    localparam logic [DATA_W-1:0] CFG_RST  = 64'h1;
    localparam logic [DATA_W-1:0] ENTRY_RST = 64'h0;

    // Kind of a retired control transfer
    typedef enum logic [2:0] {
        XF_BRANCH,
        XF_INTERRUPT,
        XF_TRAP,
        XF_FAULT,
        XF_DEBUG
    } brs_xfer_e;

endpackage

/* include/brs_ring_if.sv */
/*
 * Carrier between the stack controller and its entry storage: one
 * write port for a record pair and one indexed read port.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface brs_ring_if;
    import brs_pkg::*;

    logic                 wr_en;
    logic [PTR_W-1:0]     wr_idx;
    logic [DATA_W-1:0]    wr_src;
    logic [DATA_W-1:0]    wr_dst;
    logic [PTR_W-1:0]     rd_idx;
    logic [DATA_W-1:0]    rd_src;
    logic [DATA_W-1:0]    rd_dst;

    modport ctl   (output wr_en, wr_idx, wr_src, wr_dst, rd_idx, input rd_src, rd_dst);
    modport store (input wr_en, wr_idx, wr_src, wr_dst, rd_idx, output rd_src, rd_dst);
endinterface

/* hdl/brs_ring.sv */
/*
 * Entry storage of the branch record stack: N source and N target
 * registers in flip-flops, written as a pair, read by index.
 * Assumes the controller supplies already formatted values.
 */
`timescale 1ns/100ps
module brs_ring (
    input  wire logic    clk,
    input  wire logic    nrst,
    brs_ring_if.store    ring
);
    import brs_pkg::*;

    logic [DATA_W-1:0] src_q      [N_ENTRIES];
    logic [DATA_W-1:0] dst_q      [N_ENTRIES];
    logic [DATA_W-1:0] next_src_q [N_ENTRIES];
    logic [DATA_W-1:0] next_dst_q [N_ENTRIES];

    // Only the addressed pair changes; others hold
    always_comb begin
        for (int i = 0; i < N_ENTRIES; i++) begin
            next_src_q[i] = src_q[i];
            next_dst_q[i] = dst_q[i];
        end
        if (ring.wr_en) begin
            next_src_q[ring.wr_idx] = ring.wr_src;
            next_dst_q[ring.wr_idx] = ring.wr_dst;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < N_ENTRIES; i++) begin
                src_q[i] <= ENTRY_RST;
                dst_q[i] <= ENTRY_RST;
            end
        end else begin
            for (int i = 0; i < N_ENTRIES; i++) begin
                src_q[i] <= next_src_q[i];
                dst_q[i] <= next_dst_q[i];
            end
        end
    end

    // Read sees the pre-write value in a cycle that also writes
    assign ring.rd_src = src_q[ring.rd_idx];
    assign ring.rd_dst = dst_q[ring.rd_idx];

endmodule // brs_ring

/* hdl/brs_stack.sv */
/*
 * Branch record stack: records retired control transfers into a ring
 * of source/target pairs, keeps a newest-entry pointer, a last
 * exception record and the debug control bits that gate recording.
 * Assumes the core presents at most one transfer per clock and that
 * register strobes are single-cycle and never both high.
 */
`timescale 1ns/100ps

// Operation
// RULE1: Sixteen entry pairs; the newest-entry pointer stays within 0 to 15.
// RULE2: Every instruction pointer change is recorded: branches, interrupts, traps, faults.
// RULE3: Source register holds transfer source, target register its destination, consecutively.
// RULE4: Low pointer bits name the entry holding the newest record.
// RULE5: Entries are 64 bits; only low 32 kept when long mode off.
// RULE6: 64-bit submode keeps full address; compatibility submode clears upper half.
// RULE7: Capability bits 5:0 report the stored address format.
// RULE8: Flags format stores effective offset plus flags in source upper bits.
// RULE9: Identification bit 15 tells that the capability register exists.
// RULE10: Legacy variant packs 32-bit destination high, source low, one register.
// RULE11: Separate last exception record holds last branch before an exception.
// RULE12: Last exception record obeys the same address width handling.
// RULE13: Each record advances pointer modulo sixteen, then writes the named pair.
// RULE14: Enable bit 0 records branches, interrupts, exceptions, never debug exceptions.
// RULE15: Debug exception clears enable bit and leaves stored entries untouched.
// RULE16: With freeze bit 11 set, a monitoring interrupt clears the enable bit.
// RULE17: Enable clear but trace bit set keeps the entries updating.
module brs_stack (
    input  wire logic                       clk,
    input  wire logic                       nrst,
    input  wire logic                       xfer_valid,
    input  wire brs_pkg::brs_xfer_e         xfer_kind,
    input  wire logic [brs_pkg::DATA_W-1:0] xfer_src,
    input  wire logic [brs_pkg::DATA_W-1:0] xfer_dst,
    input  wire logic                       xfer_mispred,
    input  wire logic                       long_addressing_mode,
    input  wire logic                       submode_64,
    input  wire logic                       pmi_req,
    input  wire logic [brs_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [brs_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [brs_pkg::DATA_W-1:0] reg_rdata,
    output logic                            capability_register_present,
    output logic                            recording_active
);
    import brs_pkg::*;

    brs_ring_if ring ();

    brs_ring u_ring (
        .clk  (clk),
        .nrst (nrst),
        .ring (ring.store)
    );

    // Pointer wraps at the stack size, not at the field width
    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        if (p == PTR_W'(N_ENTRIES - 1)) begin
            return '0;
        end
        return p + PTR_W'(1);
    endfunction

    // Width handling shared by entries and the exception record
    function automatic logic [DATA_W-1:0] fit_addr(
        input logic [DATA_W-1:0] a,
        input logic              lm,
        input logic              s64,
        input logic [FMT_W-1:0]  fmt
    );
        if (!lm || !s64 || fmt == FMT_CS32) begin
            return {32'h0, a[31:0]};
        end
        return a;
    endfunction

    function automatic logic in_window(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] base
    );
        return (a >= base) && (a < base + ADDR_W'(N_ENTRIES));
    endfunction

    logic [DATA_W-1:0] ctrl;
    logic [DATA_W-1:0] cfg;
    logic [PTR_W-1:0]  ptr;
    logic [DATA_W-1:0] last_br_src;
    logic [DATA_W-1:0] last_br_dst;
    logic [DATA_W-1:0] ler_src;
    logic [DATA_W-1:0] ler_dst;
    logic [DATA_W-1:0] next_ctrl;
    logic [DATA_W-1:0] next_cfg;
    logic [PTR_W-1:0]  next_ptr;
    logic [DATA_W-1:0] next_last_br_src;
    logic [DATA_W-1:0] next_last_br_dst;
    logic [DATA_W-1:0] next_ler_src;
    logic [DATA_W-1:0] next_ler_dst;
    logic [DATA_W-1:0] next_reg_rdata;
    logic              next_active;

    logic              rec_on;
    logic              is_debug;
    logic              is_branch;
    logic              rec_fire;
    logic [FMT_W-1:0]  fmt;
    logic              pack_mode;
    logic [DATA_W-1:0] src_fit;
    logic [DATA_W-1:0] dst_fit;

    // Recording gate: trace keeps the ring alive with enable off
    assign rec_on    = ctrl[CTRL_EN_BIT] || ctrl[CTRL_TRACE_BIT]; // [RULE14] [RULE17]
    assign is_debug  = (xfer_kind == XF_DEBUG);
    assign is_branch = (xfer_kind == XF_BRANCH);
    assign rec_fire  = xfer_valid && rec_on && !is_debug; // [RULE2] [RULE14] [RULE15]
    assign fmt       = cfg[FMT_W-1:0];
    assign pack_mode = cfg[CFG_PACK_BIT];
    assign src_fit   = fit_addr(xfer_src, long_addressing_mode, submode_64, fmt); // [RULE5] [RULE6]
    assign dst_fit   = fit_addr(xfer_dst, long_addressing_mode, submode_64, fmt); // [RULE5] [RULE6]

    // Entry write port: pointer advances first, pair lands there
    always_comb begin
        ring.wr_en  = rec_fire;
        ring.wr_idx = ptr_inc(ptr); // [RULE13]
        ring.wr_src = src_fit; // [RULE3]
        ring.wr_dst = dst_fit; // [RULE3]
        if (pack_mode) begin
            ring.wr_src = {xfer_dst[31:0], xfer_src[31:0]}; // [RULE10]
            ring.wr_dst = '0;
        end else if (fmt == FMT_EIP64_FLAGS && long_addressing_mode && submode_64) begin
            ring.wr_src[FLAG_MISPRED_BIT] = xfer_mispred; // [RULE8]
        end
    end

    // Newest-entry pointer
    always_comb begin
        next_ptr = ptr;
        if (rec_fire) begin
            next_ptr = ptr_inc(ptr); // [RULE1] [RULE13]
        end
    end

    // Debug control: hardware clears win over a same-cycle write,
    // otherwise a freeze could be undone by an unlucky store
    always_comb begin
        next_ctrl = ctrl;
        if (reg_wr && reg_addr == OFS_CTRL) begin
            next_ctrl = '0;
            next_ctrl[CTRL_EN_BIT]     = reg_wdata[CTRL_EN_BIT];
            next_ctrl[CTRL_TRACE_BIT]  = reg_wdata[CTRL_TRACE_BIT];
            next_ctrl[CTRL_FREEZE_BIT] = reg_wdata[CTRL_FREEZE_BIT];
        end
        if (xfer_valid && is_debug) begin
            next_ctrl[CTRL_EN_BIT] = 1'b0; // [RULE15]
        end
        if (pmi_req && ctrl[CTRL_FREEZE_BIT]) begin
            next_ctrl[CTRL_EN_BIT] = 1'b0; // [RULE16]
        end
    end

    // Format and packing selection
    always_comb begin
        next_cfg = cfg;
        if (reg_wr && reg_addr == OFS_CFG) begin
            next_cfg = '0;
            next_cfg[FMT_W-1:0]   = reg_wdata[FMT_W-1:0];
            next_cfg[CFG_PACK_BIT] = reg_wdata[CFG_PACK_BIT];
        end
    end

    // Last branch tracking and the exception record it feeds
    always_comb begin
        next_last_br_src = last_br_src;
        next_last_br_dst = last_br_dst;
        next_ler_src     = ler_src;
        next_ler_dst     = ler_dst;
        if (xfer_valid && rec_on) begin
            if (is_branch) begin
                next_last_br_src = src_fit; // [RULE12]
                next_last_br_dst = dst_fit; // [RULE12]
            end else begin
                next_ler_src = last_br_src; // [RULE11]
                next_ler_dst = last_br_dst; // [RULE11]
            end
        end
    end

    // Read mux; data stand only in the cycle after the strobe
    always_comb begin
        ring.rd_idx    = '0;
        next_reg_rdata = '0;
        if (in_window(reg_addr, OFS_SRC_BASE)) begin
            ring.rd_idx = PTR_W'(reg_addr - OFS_SRC_BASE);
        end else if (in_window(reg_addr, OFS_DST_BASE)) begin
            ring.rd_idx = PTR_W'(reg_addr - OFS_DST_BASE);
        end
        if (reg_rd) begin
            if (in_window(reg_addr, OFS_SRC_BASE)) begin
                next_reg_rdata = ring.rd_src; // [RULE3]
            end else if (in_window(reg_addr, OFS_DST_BASE)) begin
                next_reg_rdata = ring.rd_dst; // [RULE3]
            end else begin
                case (reg_addr)
                    OFS_PTR:     next_reg_rdata = {{(DATA_W-PTR_W){1'b0}}, ptr}; // [RULE4]
                    OFS_CTRL:    next_reg_rdata = ctrl;
                    OFS_CAP:     next_reg_rdata = {{(DATA_W-FMT_W){1'b0}}, fmt}; // [RULE7]
                    OFS_LER_SRC: next_reg_rdata = ler_src;
                    OFS_LER_DST: next_reg_rdata = ler_dst;
                    OFS_CFG:     next_reg_rdata = cfg;
                    OFS_IDENT:   next_reg_rdata = DATA_W'(1) << IDENT_PRESENT_BIT; // [RULE9]
                    default:     next_reg_rdata = '0;
                endcase
            end
        end
    end

    assign next_active = ctrl[CTRL_EN_BIT] || ctrl[CTRL_TRACE_BIT];

    // All controller state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl                        <= CTRL_RST;
            cfg                         <= CFG_RST;
            ptr                         <= '0;
            last_br_src                 <= ENTRY_RST;
            last_br_dst                 <= ENTRY_RST;
            ler_src                     <= ENTRY_RST;
            ler_dst                     <= ENTRY_RST;
            reg_rdata                   <= '0;
            capability_register_present <= 1'b1; // [RULE9]
            recording_active            <= 1'b0;
        end else begin
            ctrl                        <= next_ctrl;
            cfg                         <= next_cfg;
            ptr                         <= next_ptr;
            last_br_src                 <= next_last_br_src;
            last_br_dst                 <= next_last_br_dst;
            ler_src                     <= next_ler_src;
            ler_dst                     <= next_ler_dst;
            reg_rdata                   <= next_reg_rdata;
            capability_register_present <= 1'b1;
            recording_active            <= next_active;
        end
    end

    // Checks
    sequence s_debug_event;
        xfer_valid && xfer_kind == XF_DEBUG;
    endsequence

    sequence s_enable_gone;
        !ctrl[CTRL_EN_BIT];
    endsequence

    sequence s_record;
        xfer_valid && rec_on && xfer_kind != XF_DEBUG;
    endsequence

    a_ptr_in_range: assert property ( // [RULE1]
        @(posedge clk) disable iff (!nrst)
        ptr != $past(ptr) |-> $past(rec_fire) && ptr <= PTR_W'(N_ENTRIES - 1))
        else $error("pointer moved without a record or left its range");

    a_ptr_advance: assert property ( // [RULE13]
        @(posedge clk) disable iff (!nrst)
        s_record |=> ptr == ptr_inc($past(ptr)))
        else $error("pointer did not advance by one");

    a_write_slot: assert property ( // [RULE13]
        @(posedge clk) disable iff (!nrst)
        ring.wr_en |-> ring.wr_idx == ptr_inc(ptr) ##1 ptr == $past(ring.wr_idx))
        else $error("pair written away from new pointer");

    a_debug_freeze: assert property ( // [RULE15]
        @(posedge clk) disable iff (!nrst)
        s_debug_event |-> !ring.wr_en ##1 s_enable_gone)
        else $error("debug exception recorded or enable kept");

    a_pmi_freeze: assert property ( // [RULE16]
        @(posedge clk) disable iff (!nrst)
        pmi_req && ctrl[CTRL_FREEZE_BIT] |=> s_enable_gone)
        else $error("monitoring interrupt did not freeze");

    a_trace_keeps: assert property ( // [RULE17]
        @(posedge clk) disable iff (!nrst)
        xfer_valid && !is_debug && !ctrl[CTRL_EN_BIT] && ctrl[CTRL_TRACE_BIT] |-> ring.wr_en)
        else $error("trace mode stopped updating");

    a_short_width: assert property ( // [RULE5]
        @(posedge clk) disable iff (!nrst)
        ring.wr_en && !pack_mode && !long_addressing_mode |-> ring.wr_src[63:32] == 32'h0
            && ring.wr_dst == {32'h0, xfer_dst[31:0]})
        else $error("upper half kept outside long mode");

    a_compat_clear: assert property ( // [RULE6]
        @(posedge clk) disable iff (!nrst)
        ring.wr_en && !pack_mode && long_addressing_mode && !submode_64
            |-> ring.wr_dst[63:32] == 32'h0)
        else $error("compatibility submode kept upper half");

    a_ptr_readback: assert property ( // [RULE4]
        @(posedge clk) disable iff (!nrst)
        reg_rd && reg_addr == OFS_PTR |=> reg_rdata == DATA_W'($past(ptr)))
        else $error("pointer read mismatch");

    a_cap_format: assert property ( // [RULE7]
        @(posedge clk) disable iff (!nrst)
        reg_rd && reg_addr == OFS_CAP |=> reg_rdata[FMT_W-1:0] == $past(fmt))
        else $error("capability format mismatch");

    a_ler_capture: assert property ( // [RULE11]
        @(posedge clk) disable iff (!nrst)
        xfer_valid && rec_on && !is_branch |=> ler_src == $past(last_br_src)
            && ler_dst == $past(last_br_dst))
        else $error("exception record not captured");

endmodule // brs_stack

/* verification/brs_core_model.sv */
/*
 * Model of the core's retirement and exception logic: presents each
 * retired control transfer as a single-cycle pulse.
 * Assumes the stack samples on the rising edge of clk.
 */
`timescale 1ns/100ps
module brs_core_model (
    input  wire logic                  clk,
    output logic                       xfer_valid,
    output brs_pkg::brs_xfer_e         xfer_kind,
    output logic [brs_pkg::DATA_W-1:0] xfer_src,
    output logic [brs_pkg::DATA_W-1:0] xfer_dst,
    output logic                       xfer_mispred
);
    import brs_pkg::*;

    // Idle lines carry junk so a stale value never passes as a record
    initial begin
        xfer_valid   = 1'h0;
        xfer_kind    = XF_DEBUG;
        xfer_src     = '1;
        xfer_dst     = '0;
        xfer_mispred = 1'h1;
    end

    // Raise after an edge, hold through the sampling edge, then drop
    task automatic retire(input brs_xfer_e k, input logic [DATA_W-1:0] s, d,
                          input logic mis);
        @(posedge clk);
        xfer_valid   <= 1'h1;
        xfer_kind    <= k;
        xfer_src     <= s;
        xfer_dst     <= d;
        xfer_mispred <= mis;
        @(posedge clk);
        xfer_valid   <= 1'h0;
        xfer_kind    <= XF_DEBUG;  // Worst kind while idle
        xfer_src     <= ~s;
        xfer_dst     <= ~d;
        xfer_mispred <= ~mis;
    endtask
endmodule // brs_core_model

/* verification/brs_stack_tb_top.sv */
/*
 * Self-checking bench of the branch record stack against a model.
 * Assumes brs_pkg, brs_stack and brs_core_model are compiled first.
 */
`timescale 1ns/100ps
module brs_stack_tb_top;
    import brs_pkg::*;

    logic              clk, nrst, xfer_valid, xfer_mispred, lm, s64, pmi_req;
    brs_xfer_e         xfer_kind;
    logic [DATA_W-1:0] xfer_src, xfer_dst, reg_wdata, reg_rdata;
    logic [ADDR_W-1:0] reg_addr;
    logic              reg_wr, reg_rd, cap_present, rec_active;
    int                error_cnt, check_count, m_ptr;
    logic [DATA_W-1:0] m_src [N_ENTRIES];
    logic [DATA_W-1:0] m_dst [N_ENTRIES];
    logic [DATA_W-1:0] m_ctrl, m_cfg, lb_s, lb_d, exc_s, exc_d;

    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    brs_core_model core (.clk(clk), .xfer_valid(xfer_valid), .xfer_kind(xfer_kind),
        .xfer_src(xfer_src), .xfer_dst(xfer_dst), .xfer_mispred(xfer_mispred));

    brs_stack dut (.clk(clk), .nrst(nrst), .xfer_valid(xfer_valid), .xfer_kind(xfer_kind),
        .xfer_src(xfer_src), .xfer_dst(xfer_dst), .xfer_mispred(xfer_mispred),
        .long_addressing_mode(lm), .submode_64(s64), .pmi_req(pmi_req),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .capability_register_present(cap_present),
        .recording_active(rec_active));

    // Width fitting as the current mode and format demand
    function automatic logic [DATA_W-1:0] fit(input logic [DATA_W-1:0] a,
                                              input logic mis, input logic is_src);
        logic [FMT_W-1:0] f;
        f = m_cfg[FMT_W-1:0];
        fit = (!lm || !s64 || f == FMT_CS32) ? {32'h0, a[31:0]} : a;
        if (is_src && lm && s64 && f == FMT_EIP64_FLAGS) fit[FLAG_MISPRED_BIT] = mis;
    endfunction

    task automatic chk_word(input string name, input logic [DATA_W-1:0] exp, got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_flag(input string name, input logic exp, got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic print_verdict();
        if (error_cnt == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_wr    <= 1'h1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'h0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rchk(input string name, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] exp);
        @(posedge clk);
        reg_rd   <= 1'h1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'h0;
        #1;
        chk_word(name, exp, reg_rdata);
    endtask

    task automatic pmi_pulse();
        @(posedge clk);
        pmi_req <= 1'h1;
        @(posedge clk);
        pmi_req <= 1'h0;
    endtask

    // Drive one random transfer and update the model
    task automatic rec(input brs_xfer_e k);
        logic [DATA_W-1:0] s, d;
        logic              mis;
        s   = {$urandom, $urandom};
        d   = {$urandom, $urandom};
        mis = 1'($urandom);
        core.retire(k, s, d, mis);
        if (m_ctrl[CTRL_EN_BIT] || m_ctrl[CTRL_TRACE_BIT]) begin
            if (k == XF_BRANCH) begin
                lb_s = fit(s, mis, 1'h0);  // Exception record carries no flags
                lb_d = fit(d, mis, 1'h0);
            end else begin
                exc_s = lb_s;
                exc_d = lb_d;
            end
            if (k != XF_DEBUG) begin
                m_ptr = (m_ptr + 1) % N_ENTRIES;
                m_src[m_ptr] = m_cfg[CFG_PACK_BIT] ? {d[31:0], s[31:0]} : fit(s, mis, 1'h1);
                m_dst[m_ptr] = m_cfg[CFG_PACK_BIT] ? '0 : fit(d, mis, 1'h0);
            end
        end
        if (k == XF_DEBUG) m_ctrl[CTRL_EN_BIT] = 1'h0;
    endtask

    // Pointer, control, exception record, activity flag and every entry against the model
    task automatic chk_ring();
        rchk("pointer", OFS_PTR, 64'(m_ptr));
        rchk("control", OFS_CTRL, m_ctrl);
        rchk("exc_src", OFS_LER_SRC, exc_s);
        rchk("exc_dst", OFS_LER_DST, exc_d);
        chk_flag("rec_active", m_ctrl[CTRL_EN_BIT] | m_ctrl[CTRL_TRACE_BIT], rec_active);
        for (int i = 0; i < N_ENTRIES; i++) begin
            rchk("src_entry", OFS_SRC_BASE + ADDR_W'(i), m_src[i]);
            rchk("dst_entry", OFS_DST_BASE + ADDR_W'(i), m_dst[i]);
        end
    endtask

    // Guard against a hang
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end

    initial begin
        nrst = 1'h0;
        lm = 1'h1;
        s64 = 1'h1;
        pmi_req = 1'h0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        error_cnt = 0;
        check_count = 0;
        m_ptr = 0;
        m_ctrl = CTRL_RST;
        m_cfg = CFG_RST;
        {lb_s, lb_d, exc_s, exc_d} = '0;
        foreach (m_src[i]) {m_src[i], m_dst[i]} = {ENTRY_RST, ENTRY_RST};
        void'($urandom(32'h87CB));
        repeat (2) @(posedge clk);
        nrst <= 1'h1;
        // Reset values, read-only and unmapped places
        chk_flag("cap_present", 1'h1, cap_present);
        rchk("ident", OFS_IDENT, 64'h1 << IDENT_PRESENT_BIT);
        rchk("config", OFS_CFG, CFG_RST);
        rchk("capability", OFS_CAP, 64'(FMT_LIP64));
        wr(OFS_PTR, 64'h5);
        rchk("unmapped", 8'h08, 64'h0);
        chk_ring();
        // Seventeen branches wrap the pointer past the last entry
        wr(OFS_CTRL, 64'h1);
        m_ctrl = 64'h1;
        repeat (N_ENTRIES + 1) rec(XF_BRANCH);
        chk_ring();
        // Interrupt, trap and fault are each recorded and snapshot the last branch
        for (int j = 1; j < 4; j++) begin
            rec(XF_BRANCH);
            rec(brs_xfer_e'(j));
            chk_ring();
        end
        // Long mode off, then compatibility submode
        for (int j = 0; j < 2; j++) begin
            @(posedge clk);
            lm  <= 1'(j);
            s64 <= 1'(1 - j);
            rec(XF_BRANCH);
            rec(XF_FAULT);
            chk_ring();
        end
        @(posedge clk);
        lm  <= 1'h1;
        s64 <= 1'h1;
        // Debug transfer disables recording and leaves entries alone
        rec(XF_DEBUG);
        chk_ring();
        rec(XF_BRANCH);
        chk_ring();
        // Only the defined control bits stick; freeze clears enable
        wr(OFS_CTRL, '1);
        m_ctrl = 64'h841;
        rchk("control", OFS_CTRL, m_ctrl);
        pmi_pulse();
        m_ctrl[CTRL_EN_BIT] = 1'h0;
        rec(XF_BRANCH);
        chk_ring();
        wr(OFS_CTRL, 64'h1);
        m_ctrl = 64'h1;
        pmi_pulse();
        rchk("control", OFS_CTRL, m_ctrl);
        // Every stored address format, flags last
        for (int f = 0; f < 4; f++) begin
            wr(OFS_CFG, 64'(f));
            m_cfg = 64'(f);
            rchk("capability", OFS_CAP, 64'(f));
            repeat (2) rec(XF_BRANCH);
            rec(XF_TRAP);
            chk_ring();
        end
        // Packed legacy layout
        wr(OFS_CFG, 64'h101);
        m_cfg = 64'h101;
        repeat (3) rec(XF_BRANCH);
        chk_ring();
        print_verdict();
    end
endmodule // brs_stack_tb_top
